// ==== msr_regs.v ====
`timescale 1ns/1ps
`default_nettype none
`include "msr_map.vh"
module msr_regs #(
	parameter [7:0] IDENTITY_CODE = 8'h5a,
	parameter QW = `MSR_QCOUNT_WIDTH
) (
	// Clock and reset.
	input wire clk,
	input wire sys_rst,
	// Register port.
	input wire [6:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	// Sensor datapath.
	input wire [15:0] accel_z_measurement,
	input wire [15:0] temperature_measurement,
	input wire [15:0] rate_x_measurement,
	input wire [15:0] rate_y_measurement,
	input wire [15:0] rate_z_measurement,
	input wire [QW-1:0] queue_count,
	input wire [7:0] queue_rdata,
	output reg queue_read_pulse,
	output reg queue_write_pulse,
	output reg [7:0] queue_wdata,
	// Control out.
	output reg measure_enable,
	output reg [7:0] path_reset_out,
	output reg [7:0] motion_ctl_out,
	output reg [7:0] host_ctl_out,
	output reg [7:0] pwr_primary_out,
	output reg [7:0] pwr_axes_out,
	output reg [44:0] accel_trim_out
);
	// ****************************************
	// Control registers
	// ****************************************
	reg [7:0] path_rst_reg;
	reg [7:0] motion_ctl_reg;
	reg [7:0] host_ctl_reg;
	reg [7:0] pwr_primary_reg;
	reg [7:0] pwr_axes_reg;
	reg [79:0] snap_reg;
	wire asleep;
	wire wr_ok;
	wire soft_rst;
	assign asleep = pwr_primary_reg[`MSR_SLEEP_BIT];
	// Writes while asleep go only to the power registers.
	assign wr_ok = reg_wr & ~asleep;
	assign soft_rst = wr_pwr_primary & reg_wdata[`MSR_DEVICE_RESET_BIT];
	// ****************************************
	// Write decode
	// ****************************************
	// The power registers stay writable while asleep so the host can wake.
	wire wr_path_rst;
	wire wr_motion_ctl;
	wire wr_host_ctl;
	wire wr_pwr_primary;
	wire wr_pwr_axes;
	wire wr_qdata;
	wire rd_qdata;
	wire wr_ax_hi;
	wire wr_ax_lo;
	wire wr_ay_hi;
	wire wr_ay_lo;
	wire wr_az_hi;
	wire wr_az_lo;
	assign wr_path_rst = wr_ok && reg_addr == `MSR_ADDR_PATH_RST;
	assign wr_motion_ctl = wr_ok && reg_addr == `MSR_ADDR_MOTION_CTL;
	assign wr_host_ctl = wr_ok && reg_addr == `MSR_ADDR_HOST_CTL;
	assign wr_pwr_primary = reg_wr && reg_addr == `MSR_ADDR_PWR_PRIMARY;
	assign wr_pwr_axes = reg_wr && reg_addr == `MSR_ADDR_PWR_AXES;
	assign wr_qdata = wr_ok && reg_addr == `MSR_ADDR_QDATA;
	assign rd_qdata = reg_rd && reg_addr == `MSR_ADDR_QDATA;
	assign wr_ax_hi = wr_ok && reg_addr == `MSR_ADDR_AX_TRIM_HIGH;
	assign wr_ax_lo = wr_ok && reg_addr == `MSR_ADDR_AX_TRIM_LOW;
	assign wr_ay_hi = wr_ok && reg_addr == `MSR_ADDR_AY_TRIM_HIGH;
	assign wr_ay_lo = wr_ok && reg_addr == `MSR_ADDR_AY_TRIM_LOW;
	assign wr_az_hi = wr_ok && reg_addr == `MSR_ADDR_AZ_TRIM_HIGH;
	assign wr_az_lo = wr_ok && reg_addr == `MSR_ADDR_AZ_TRIM_LOW;
	always @(posedge clk) begin
		if (sys_rst | soft_rst) begin
			path_rst_reg <= `MSR_RESET_ZERO;
			motion_ctl_reg <= `MSR_RESET_ZERO;
			host_ctl_reg <= `MSR_RESET_ZERO;
			pwr_primary_reg <= `MSR_RESET_PWR_PRIMARY;
			pwr_axes_reg <= `MSR_RESET_ZERO;
		end else begin
			if (wr_path_rst) begin
				path_rst_reg <= reg_wdata;
			end
			if (wr_motion_ctl) begin
				motion_ctl_reg <= reg_wdata;
			end
			if (wr_host_ctl) begin
				host_ctl_reg <= reg_wdata;
			end
			if (wr_pwr_primary) begin
				pwr_primary_reg <= reg_wdata;
			end
			if (wr_pwr_axes) begin
				pwr_axes_reg <= reg_wdata;
			end
		end
	end
	// ****************************************
	// Measurement capture
	// ****************************************
	// Sampling freezes while asleep so the host sees the last value held.
	always @(posedge clk) begin
		if (sys_rst) begin
			snap_reg <= 80'h0;
		end else if (!asleep) begin
			snap_reg <= {accel_z_measurement, temperature_measurement,
				rate_x_measurement, rate_y_measurement, rate_z_measurement};
		end
	end
	wire [7:0] m_hi [0:4];
	wire [7:0] m_lo [0:4];
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : gen_split
			msr_split16 u_split (
				.value(snap_reg[79-16*g -: 16]),
				.high_byte(m_hi[g]),
				.low_byte(m_lo[g])
			);
		end
	endgenerate
	// ****************************************
	// Accelerometer trim
	// ****************************************
	wire [14:0] trim_x;
	wire [14:0] trim_y;
	wire [14:0] trim_z;
	wire [7:0] tx_hi;
	wire [7:0] tx_lo;
	wire [7:0] ty_hi;
	wire [7:0] ty_lo;
	wire [7:0] tz_hi;
	wire [7:0] tz_lo;
	msr_trim15 u_trim_x (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_high(wr_ax_hi),
		.wr_low(wr_ax_lo),
		.wdata(reg_wdata),
		.trim(trim_x),
		.high_byte(tx_hi),
		.low_byte(tx_lo)
	);
	msr_trim15 u_trim_y (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_high(wr_ay_hi),
		.wr_low(wr_ay_lo),
		.wdata(reg_wdata),
		.trim(trim_y),
		.high_byte(ty_hi),
		.low_byte(ty_lo)
	);
	msr_trim15 u_trim_z (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_high(wr_az_hi),
		.wr_low(wr_az_lo),
		.wdata(reg_wdata),
		.trim(trim_z),
		.high_byte(tz_hi),
		.low_byte(tz_lo)
	);
	// ****************************************
	// Read mux
	// ****************************************
	reg [7:0] rd_next;
	wire [15:0] qcount16;
	assign qcount16 = {{(16-QW){1'b0}}, queue_count};
	always @* begin
		case (reg_addr)
		`MSR_ADDR_AZ_HIGH: rd_next = m_hi[0];
		`MSR_ADDR_AZ_LOW: rd_next = m_lo[0];
		`MSR_ADDR_TEMP_HIGH: rd_next = m_hi[1];
		`MSR_ADDR_TEMP_LOW: rd_next = m_lo[1];
		`MSR_ADDR_RX_HIGH: rd_next = m_hi[2];
		`MSR_ADDR_RX_LOW: rd_next = m_lo[2];
		`MSR_ADDR_RY_HIGH: rd_next = m_hi[3];
		`MSR_ADDR_RY_LOW: rd_next = m_lo[3];
		`MSR_ADDR_RZ_HIGH: rd_next = m_hi[4];
		`MSR_ADDR_RZ_LOW: rd_next = m_lo[4];
		`MSR_ADDR_PATH_RST: rd_next = path_rst_reg;
		`MSR_ADDR_MOTION_CTL: rd_next = motion_ctl_reg;
		`MSR_ADDR_HOST_CTL: rd_next = host_ctl_reg;
		`MSR_ADDR_PWR_PRIMARY: rd_next = pwr_primary_reg;
		`MSR_ADDR_PWR_AXES: rd_next = pwr_axes_reg;
		`MSR_ADDR_QCOUNT_HIGH: rd_next = qcount16[15:8];
		`MSR_ADDR_QCOUNT_LOW: rd_next = qcount16[7:0];
		`MSR_ADDR_QDATA: rd_next = queue_rdata;
		`MSR_ADDR_IDENTITY: rd_next = IDENTITY_CODE;
		`MSR_ADDR_AX_TRIM_HIGH: rd_next = tx_hi;
		`MSR_ADDR_AX_TRIM_LOW: rd_next = tx_lo;
		`MSR_ADDR_AY_TRIM_HIGH: rd_next = ty_hi;
		`MSR_ADDR_AY_TRIM_LOW: rd_next = ty_lo;
		`MSR_ADDR_AZ_TRIM_HIGH: rd_next = tz_hi;
		`MSR_ADDR_AZ_TRIM_LOW: rd_next = tz_lo;
		default: rd_next = `MSR_RESET_ZERO;
		endcase
	end
	// ****************************************
	// Registered outputs
	// ****************************************
	always @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= `MSR_RESET_ZERO;
			queue_read_pulse <= 1'b0;
			queue_write_pulse <= 1'b0;
			queue_wdata <= `MSR_RESET_ZERO;
			measure_enable <= 1'b0;
			path_reset_out <= `MSR_RESET_ZERO;
			motion_ctl_out <= `MSR_RESET_ZERO;
			host_ctl_out <= `MSR_RESET_ZERO;
			pwr_primary_out <= `MSR_RESET_PWR_PRIMARY;
			pwr_axes_out <= `MSR_RESET_ZERO;
			accel_trim_out <= 45'h0;
		end else begin
			if (reg_rd) begin
				reg_rdata <= rd_next;
			end
			queue_read_pulse <= rd_qdata;
			queue_write_pulse <= wr_qdata;
			if (wr_qdata) begin
				queue_wdata <= reg_wdata;
			end
			measure_enable <= ~asleep;
			path_reset_out <= path_rst_reg;
			motion_ctl_out <= motion_ctl_reg;
			host_ctl_out <= host_ctl_reg;
			pwr_primary_out <= pwr_primary_reg;
			pwr_axes_out <= pwr_axes_reg;
			accel_trim_out <= {trim_x, trim_y, trim_z};
		end
	end
endmodule
`default_nettype wire

// ==== msr_map.vh ====
`ifndef MSR_MAP_VH
`define MSR_MAP_VH
`define MSR_ADDR_AZ_HIGH 7'h3f
`define MSR_ADDR_AZ_LOW 7'h40
`define MSR_ADDR_TEMP_HIGH 7'h41
`define MSR_ADDR_TEMP_LOW 7'h42
`define MSR_ADDR_RX_HIGH 7'h43
`define MSR_ADDR_RX_LOW 7'h44
`define MSR_ADDR_RY_HIGH 7'h45
`define MSR_ADDR_RY_LOW 7'h46
`define MSR_ADDR_RZ_HIGH 7'h47
`define MSR_ADDR_RZ_LOW 7'h48
`define MSR_ADDR_PATH_RST 7'h68
`define MSR_ADDR_MOTION_CTL 7'h69
`define MSR_ADDR_HOST_CTL 7'h6a
`define MSR_ADDR_PWR_PRIMARY 7'h6b
`define MSR_ADDR_PWR_AXES 7'h6c
`define MSR_ADDR_QCOUNT_HIGH 7'h72
`define MSR_ADDR_QCOUNT_LOW 7'h73
`define MSR_ADDR_QDATA 7'h74
`define MSR_ADDR_IDENTITY 7'h75
`define MSR_ADDR_AX_TRIM_HIGH 7'h77
`define MSR_ADDR_AX_TRIM_LOW 7'h78
`define MSR_ADDR_AY_TRIM_HIGH 7'h7a
`define MSR_ADDR_AY_TRIM_LOW 7'h7b
`define MSR_ADDR_AZ_TRIM_HIGH 7'h7d
`define MSR_ADDR_AZ_TRIM_LOW 7'h7e
`define MSR_RESET_ZERO 8'h00
`define MSR_RESET_PWR_PRIMARY 8'h40
`define MSR_SLEEP_BIT 6
`define MSR_DEVICE_RESET_BIT 7
`define MSR_QCOUNT_WIDTH 13
`endif

// ==== msr_split16.v ====
`timescale 1ns/1ps
`default_nettype none
module msr_split16 (
	// Measurement in.
	input wire [15:0] value,
	// Byte views.
	output wire [7:0] high_byte,
	output wire [7:0] low_byte
);
	assign high_byte = value[15:8];
	assign low_byte = value[7:0];
endmodule
`default_nettype wire

// ==== msr_trim15.v ====
`timescale 1ns/1ps
`default_nettype none
module msr_trim15 (
	// Clock and reset.
	input wire clk,
	input wire sys_rst,
	// Byte writes.
	input wire wr_high,
	input wire wr_low,
	input wire [7:0] wdata,
	// Offset and byte views.
	output wire [14:0] trim,
	output wire [7:0] high_byte,
	output wire [7:0] low_byte
);
	reg [14:0] trim_reg;
	always @(posedge clk) begin
		if (sys_rst) begin
			trim_reg <= 15'h0000;
		end else begin
			if (wr_high) begin
				trim_reg[14:7] <= wdata;
			end
			if (wr_low) begin
				trim_reg[6:0] <= wdata[7:1];
			end
		end
	end
	assign trim = trim_reg;
	assign high_byte = trim_reg[14:7];
	// The unused low bit reads as zero.
	assign low_byte = {trim_reg[6:0], 1'b0};
endmodule
`default_nettype wire

// ==== msr_regs_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module msr_regs_checker #(
	parameter [7:0] IDENTITY_CODE = 8'h5a,
	parameter QW = 13
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Register port.
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Datapath and control.
	input wire logic [QW-1:0] queue_count,
	input wire logic measure_enable,
	input wire logic [7:0] path_reset_out,
	input wire logic [7:0] pwr_primary_out
);
	// ****************************************
	// Properties.
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// The output copy lags one cycle, so sleep is judged one cycle late.
	sequence s_wr_asleep;
		reg_wr && reg_addr == 7'h68 ##1 pwr_primary_out[6];
	endsequence
	sequence s_wake;
		reg_wr && reg_addr == 7'h6b && reg_wdata[7:6] == 2'b00;
	endsequence
	a_id_read: assert property (
		reg_rd && reg_addr == 7'h75 |=> reg_rdata == IDENTITY_CODE)
		else $error("identity read wrong");
	a_reset_power: assert property (
		$fell(sys_rst) |-> pwr_primary_out == 8'h40 && !measure_enable
		&& path_reset_out == 8'h00 && reg_rdata == 8'h00)
		else $error("reset values wrong");
	a_sleep_halts: assert property (
		measure_enable == !pwr_primary_out[6])
		else $error("measurement runs while asleep");
	a_wake_measure: assert property (
		s_wake |=> ##1 measure_enable)
		else $error("no measurement after wake");
	a_asleep_refuse: assert property (
		s_wr_asleep |=> $stable(path_reset_out))
		else $error("write accepted while asleep");
	a_count_high: assert property (
		reg_rd && reg_addr == 7'h72 && $stable(queue_count)
		|=> reg_rdata == {3'b000, $past(queue_count[12:8])})
		else $error("count high byte wrong");
	a_count_low: assert property (
		reg_rd && reg_addr == 7'h73 && $stable(queue_count)
		|=> reg_rdata == $past(queue_count[7:0]))
		else $error("count low byte wrong");
	a_unmapped_zero: assert property (
		reg_rd && reg_addr == 7'h50 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind msr_regs msr_regs_checker #(.IDENTITY_CODE(IDENTITY_CODE), .QW(QW)) u_chk (
	.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.queue_count(queue_count), .measure_enable(measure_enable),
	.path_reset_out(path_reset_out), .pwr_primary_out(pwr_primary_out));
`default_nettype wire

// ==== msr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module msr_host_model (
	// Clock.
	input wire logic clk,
	// Register port.
	output logic [6:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	// ****************************************
	// Host register cycles.
	// ****************************************
	initial begin
		reg_addr = 7'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// Released lines show the inverse so stale values never look valid.
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ==== test_motion_sensor_output_power_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_motion_sensor_output_power_regs;
	// Arbitrary identity value.
	localparam logic [7:0] ID = 8'h96;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] m [5] = '{16'h1234, 16'hfe01, 16'h8002, 16'h7f10, 16'h00ff};
	logic [12:0] qc = 13'h1abc;
	logic [7:0] qr = 8'h3c;
	wire [6:0] addr;
	wire wr, rd, me;
	wire [7:0] wd, rdat, qwd;
	wire [44:0] trim;
	int error_cnt = 0;
	int n_checks = 0;
	logic [7:0] v;
	always #5 clk = ~clk;
	msr_host_model host (.clk(clk), .reg_addr(addr), .reg_wr(wr),
		.reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdat));
	msr_regs #(.IDENTITY_CODE(ID)) dut (.clk(clk), .sys_rst(sys_rst),
		.reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd),
		.reg_rdata(rdat), .accel_z_measurement(m[0]),
		.temperature_measurement(m[1]), .rate_x_measurement(m[2]),
		.rate_y_measurement(m[3]), .rate_z_measurement(m[4]),
		.queue_count(qc), .queue_rdata(qr), .queue_read_pulse(),
		.queue_write_pulse(), .queue_wdata(qwd), .measure_enable(me),
		.path_reset_out(), .motion_ctl_out(), .host_ctl_out(),
		.pwr_primary_out(), .pwr_axes_out(), .accel_trim_out(trim));
	// ****************************************
	// Scenarios.
	// ****************************************
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task t_reset;
		host.rd(7'h6b, v); chk(v, 8'h40);
		host.rd(7'h75, v); chk(v, ID);
		host.rd(7'h68, v); chk(v, 8'h00);
		host.rd(7'h3f, v); chk(v, 8'h00);
		host.rd(7'h50, v); chk(v, 8'h00);
	endtask
	task t_sleep;
		host.wr(7'h68, 8'h55);
		host.wr(7'h6c, 8'h3f);
		host.rd(7'h68, v); chk(v, 8'h00);
		host.rd(7'h6c, v); chk(v, 8'h3f);
		chk({7'h00, me}, 8'h00);
	endtask
	task t_wake;
		// Sleep is cleared before any other register is touched.
		host.wr(7'h6b, 8'h00);
		host.rd(7'h6b, v); chk(v, 8'h00);
		chk({7'h00, me}, 8'h01);
		host.wr(7'h68, 8'h55);
		host.rd(7'h68, v); chk(v, 8'h55);
	endtask
	task t_split;
		for (int i = 0; i < 10; i++) begin
			host.rd(7'(7'h3f + i), v);
			chk(v, i[0] ? m[i/2][7:0] : m[i/2][15:8]);
		end
		host.rd(7'h72, v); chk(v, {3'b000, qc[12:8]});
		host.rd(7'h73, v); chk(v, qc[7:0]);
		host.wr(7'h77, 8'ha5);
		host.wr(7'h78, 8'h81);
		host.rd(7'h78, v); chk(v, 8'h80);
		chk(trim[44:37], 8'ha5);
		chk({trim[36:30], 1'b0}, 8'h80);
		host.wr(7'h74, 8'h6e);
		host.rd(7'h74, v); chk(v, qr);
		chk(qwd, 8'h6e);
		// Setting the device reset bit brings the control bank back asleep.
		host.wr(7'h6b, 8'h80);
		host.rd(7'h6b, v); chk(v, 8'h40);
		host.rd(7'h68, v); chk(v, 8'h00);
		chk({7'h00, me}, 8'h00);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		t_reset;
		t_sleep;
		t_wake;
		t_split;
		end_sim;
	end
	// The tests take under a hundred cycles; this allows ample margin.
	initial begin
		#20000;
		error_cnt++;
		end_sim;
	end
endmodule
`default_nettype wire
